// [electronic_gear_follower.sv]
// electronic gear follower: reference decode, gear scaling, mode control
// assumes reference pins and enable are asynchronous, the rest is mclk logic
`timescale 1ns/100ps
module electronic_gear_follower (
    input wire logic mclk, // 125 MHz control clock
    input wire logic nrst, // async reset, active low
    input wire gear_pkg::ref_pins_t ref_pins, // a/pulse and b/dir pins
    input wire logic reference_input_format_select, // 0 quadrature, 1 pulse/dir
    input wire logic fieldbus_ctrl, // 1 fieldbus, 0 local control
    input wire logic enable_pin, // local enable input
    input wire logic [3:0] local_default_operating_mode, // local start mode
    input wire logic bus_opmode_wr, // one-cycle write of bus mode
    input wire logic [3:0] bus_operating_mode_select, // bus mode value
    input wire logic halt_req, // halt request level
    input wire logic fault, // drive error level
    input wire logic motor_standstill, // motor at rest
    input wire gear_pkg::par_req_t par_req, // parameter access
    output logic [31:0] par_rdata, // parameter read data
    output logic power_stage_on, // power amplifier active
    output logic gear_active, // gear follows reference
    output logic signed [31:0] set_position, // target, internal units
    output logic [16:0] set_angle, // position within one revolution
    output logic signed [31:0] set_revs // whole revolutions
);
    import gear_pkg::*;

    // synchronisers, first stage only feeds second
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic a_prev_r; // last synced a/pulse
    logic b_prev_r; // last synced b
    logic en_prev_r; // last synced enable

    // parameters
    logic [15:0] sync_type_r;
    logic signed [31:0] num_r;
    logic [31:0] den_r;
    logic [31:0] den_shadow_r; // waits for numerator write
    logic [15:0] dir_rel_r;

    // state and datapath
    gear_state_t state_r;
    gear_state_t state_nxt;
    logic signed [63:0] frac_r; // scaled remainder
    logic signed [31:0] pending_r; // counts during interruption
    logic signed [31:0] pos_r;
    logic [16:0] angle_r;
    logic signed [31:0] revs_r;
    logic [31:0] rdata_r;
    logic power_r;

    // synced pin views
    wire a_s = sync2_r[0];
    wire b_s = sync2_r[1];
    wire en_s = sync2_r[2];

    // quadrature: one step per edge of either channel
    wire quad_edge = (a_s ^ a_prev_r) | (b_s ^ b_prev_r);
    wire quad_up = quad_edge & ((a_s ^ b_prev_r) == 1'b1);
    wire quad_dn = quad_edge & ~quad_up;
    // pulse/direction: rising pulse edge, dir high counts down
    wire pd_edge = a_s & ~a_prev_r;
    wire pd_up = pd_edge & ~b_s;
    wire pd_dn = pd_edge & b_s;
    wire ref_up = reference_input_format_select ? pd_up : quad_up; // R1
    wire ref_dn = reference_input_format_select ? pd_dn : quad_dn; // R1
    wire ref_any = ref_up | ref_dn;

    // parameter write decode
    wire wr_sync = par_req.wr & (par_req.addr == OFS_SYNC_TYPE);
    wire wr_num = par_req.wr & (par_req.addr == OFS_RATIO_NUM);
    wire wr_den = par_req.wr & (par_req.addr == OFS_RATIO_DEN);
    wire wr_dir = par_req.wr & (par_req.addr == OFS_DIR_REL);
    wire [15:0] wsync = par_req.wdata[15:0];
    wire [15:0] wdir = par_req.wdata[15:0];
    wire sync_ok = wr_sync & (wsync <= SYNC_MAX); // R12
    wire den_ok = wr_den & (par_req.wdata != 32'h0000_0000) & ~par_req.wdata[31];
    wire dir_ok = wr_dir & (wdir >= DIR_POS) & (wdir <= DIR_BOTH);

    // start and stop events
    wire en_rise = en_s & ~en_prev_r;
    wire local_start = ~fieldbus_ctrl & en_rise & (local_default_operating_mode == OPMODE_GEAR); // R2
    wire bus_mode_start = fieldbus_ctrl & bus_opmode_wr & (bus_operating_mode_select == OPMODE_GEAR); // R3
    wire sync_start = fieldbus_ctrl & sync_ok & (wsync != SYNC_OFF); // R4
    wire start_req = local_start | bus_mode_start | sync_start;
    wire bus_disable = (bus_opmode_wr & (bus_operating_mode_select != OPMODE_GEAR)) | (sync_ok & (wsync == SYNC_OFF));
    wire disable_req = fieldbus_ctrl ? bus_disable : ~en_s;
    wire abort = halt_req | fault; // R7
    wire running = (state_r == ST_RUN);
    // replay of counted changes on resume: compensate replays, realtime drops
    wire replay_keep = fieldbus_ctrl & (sync_type_r == SYNC_COMPENSATE); // R11

    // gear step: live reference first, then replayed counts
    // gated by replay_keep: in realtime the counts are cleared on the first
    // running cycle, and must not leak one step out before that
    wire replay_up = running & replay_keep & ~ref_any & (pending_r > 32'sh0000_0000); // R11
    wire replay_dn = running & replay_keep & ~ref_any & (pending_r < 32'sh0000_0000); // R11
    wire step_up = (running & ref_up) | replay_up;
    wire step_dn = (running & ref_dn) | replay_dn;
    wire signed [63:0] num_x = {{32{num_r[31]}}, num_r};
    wire signed [63:0] den_x = {32'h0000_0000, den_r};
    // sign of numerator sets motor direction
    wire signed [63:0] frac_in = step_up ? frac_r + num_x : (step_dn ? frac_r - num_x : frac_r); // R13
    wire mot_fwd = (frac_in >= den_x); // R16
    wire mot_rev = (frac_in <= -den_x); // R16
    // direction release applies in every sync type
    wire fwd_ok = (dir_rel_r == DIR_POS) | (dir_rel_r == DIR_BOTH); // R15
    wire rev_ok = (dir_rel_r == DIR_NEG) | (dir_rel_r == DIR_BOTH); // R15
    wire frac_hold = running | (state_r == ST_STOP);
    wire signed [63:0] frac_nxt = mot_fwd ? frac_in - den_x : (mot_rev ? frac_in + den_x : frac_in);
    wire pos_inc = frac_hold & mot_fwd & fwd_ok; // R9
    wire pos_dec = frac_hold & mot_rev & rev_ok; // R9

    // state transitions
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:
            begin
                if (start_req & ~abort)
                    state_nxt = ST_RUN;
            end
            ST_RUN:
            begin
                if (abort)
                    state_nxt = ST_IDLE; // R7
                else if (disable_req)
                    state_nxt = ST_STOP;
            end
            ST_STOP:
            begin
                if (abort | motor_standstill)
                    state_nxt = ST_IDLE; // R7
                else if (start_req)
                    state_nxt = ST_RUN;
            end
        endcase
    end

    // pin synchronisers
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            a_prev_r <= 1'b0;
            b_prev_r <= 1'b0;
            en_prev_r <= 1'b0;
        end
        else
        begin
            sync1_r <= {enable_pin, ref_pins.b_dir, ref_pins.a_pulse};
            sync2_r <= sync1_r;
            a_prev_r <= a_s;
            b_prev_r <= b_s;
            en_prev_r <= en_s;
        end
    end

    // parameter registers; a new ratio takes effect with the numerator
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_type_r <= SYNC_RESET; // R12
            num_r <= NUM_RESET; // R14
            den_r <= DEN_RESET; // R14
            den_shadow_r <= DEN_RESET;
            dir_rel_r <= DIR_BOTH; // R15
        end
        else
        begin
            if (sync_ok)
                sync_type_r <= wsync; // R4
            if (den_ok)
                den_shadow_r <= par_req.wdata;
            if (wr_num)
            begin
                num_r <= par_req.wdata; // R13
                den_r <= den_ok ? par_req.wdata : den_shadow_r;
            end
            // out-of-range codes are ignored
            if (dir_ok)
                dir_rel_r <= wdir;
        end
    end

    // read port, unmapped offsets read zero
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            rdata_r <= 32'h0000_0000;
        else if (par_req.rd)
        begin
            unique case (par_req.addr)
                OFS_SYNC_TYPE: rdata_r <= {16'h0000, sync_type_r};
                OFS_RATIO_NUM: rdata_r <= num_r;
                OFS_RATIO_DEN: rdata_r <= den_shadow_r;
                OFS_DIR_REL: rdata_r <= {16'h0000, dir_rel_r};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // state and power stage
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= ST_IDLE;
            power_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            power_r <= (state_nxt != ST_IDLE); // R2
        end
    end

    // counts seen while not following
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            pending_r <= 32'sh0000_0000;
        else if (!fieldbus_ctrl)
            pending_r <= 32'sh0000_0000; // R10
        else if (!running)
        begin
            // saturation not needed: 2^31 counts outlast any pause
            if (ref_up)
                pending_r <= pending_r + 32'sh0000_0001; // R11
            else if (ref_dn)
                pending_r <= pending_r - 32'sh0000_0001; // R11
        end
        else if (state_r != state_nxt || !replay_keep)
            pending_r <= replay_keep ? pending_r : 32'sh0000_0000; // R11
        else if (replay_up)
            pending_r <= pending_r - 32'sh0000_0001;
        else if (replay_dn)
            pending_r <= pending_r + 32'sh0000_0001;
    end

    // gear datapath: one motor increment per cycle at most, so very large
    // numerators lag the reference but never lose increments
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            frac_r <= 64'sh0000_0000_0000_0000;
            pos_r <= 32'sh0000_0000;
            angle_r <= 17'h0_0000;
            revs_r <= 32'sh0000_0000;
        end
        else
        begin
            if (frac_hold)
                frac_r <= frac_nxt; // R16
            else
                frac_r <= 64'sh0000_0000_0000_0000;
            if (pos_inc)
            begin
                pos_r <= pos_r + 32'sh0000_0001; // R5 R6
                angle_r <= (angle_r == INC_PER_REV_M1) ? 17'h0_0000 : angle_r + 17'h0_0001; // R8
                if (angle_r == INC_PER_REV_M1)
                    revs_r <= revs_r + 32'sh0000_0001; // R8
            end
            else if (pos_dec)
            begin
                pos_r <= pos_r - 32'sh0000_0001; // R5 R6
                angle_r <= (angle_r == 17'h0_0000) ? INC_PER_REV_M1 : angle_r - 17'h0_0001; // R8
                if (angle_r == 17'h0_0000)
                    revs_r <= revs_r - 32'sh0000_0001; // R8
            end
        end
    end

    assign par_rdata = rdata_r;
    assign power_stage_on = power_r;
    assign gear_active = state_r[1];
    assign set_position = pos_r;
    assign set_angle = angle_r;
    assign set_revs = revs_r;
endmodule

// [electronic_gear_follower_tb_top.sv]
// top bench for the gear follower: scenarios, checker bind, verdict
// assumes gear_pkg, the follower and the reference source compile first
`timescale 1ns/100ps
module electronic_gear_follower_tb_top;
    import gear_pkg::*;
    logic mclk, nrst, reference_input_format_select, fieldbus_ctrl, enable_pin; // drive inputs
    logic [3:0] local_default_operating_mode, bus_operating_mode_select; // mode codes
    logic bus_opmode_wr, halt_req, fault, motor_standstill; // control levels
    ref_pins_t ref_pins; // from reference source
    par_req_t par_req; // parameter access
    logic [31:0] par_rdata; // read data
    logic power_stage_on, gear_active; // state flags
    logic signed [31:0] set_position, set_revs; // targets
    logic [16:0] set_angle; // angle within revolution
    int failures, tests_run; // tallies
    electronic_gear_follower dut (
        .mclk(mclk), .nrst(nrst), .ref_pins(ref_pins),
        .reference_input_format_select(reference_input_format_select),
        .fieldbus_ctrl(fieldbus_ctrl), .enable_pin(enable_pin),
        .local_default_operating_mode(local_default_operating_mode),
        .bus_opmode_wr(bus_opmode_wr), .bus_operating_mode_select(bus_operating_mode_select),
        .halt_req(halt_req), .fault(fault), .motor_standstill(motor_standstill),
        .par_req(par_req), .par_rdata(par_rdata), .power_stage_on(power_stage_on),
        .gear_active(gear_active), .set_position(set_position), .set_angle(set_angle),
        .set_revs(set_revs)
    );
    nc_ref_source nc (.mclk(mclk), .pins(ref_pins));
    task automatic finish_test;
        if (failures == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // one-cycle access, then a gap so strobes never retrigger in one step
    task automatic pw(input logic w, input logic [15:0] a, input logic [31:0] d);
        par_req = '{w, !w, a, d};
        tick(1);
        par_req = '0;
        tick(1);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        pw(1'b0, a, 32'h0000_0000);
        tick(1);
        chk("par_rdata", e, par_rdata);
    endtask
    task automatic bop(input logic [3:0] v);
        bus_operating_mode_select = v;
        bus_opmode_wr = 1'b1;
        tick(1);
        bus_opmode_wr = 1'b0;
        tick(1);
    endtask
    // bounded wait for the running flag
    task automatic act(input logic v);
        for (int i = 0; i < 20 && gear_active !== v; i++) tick(1);
        chk("gear_active", 32'(v), 32'(gear_active));
    endtask
    task automatic pos(input logic signed [31:0] e);
        chk("set_position", e, set_position);
        chk("set_angle", {15'h0000, e[16:0]}, {15'h0000, set_angle});
        chk("set_revs", e >>> 17, set_revs);
    endtask
    // bus interruption with n reference steps seen meanwhile
    task automatic gap(input int n);
        pw(1'b1, OFS_SYNC_TYPE, 32'h0000_0000);
        act(1'b0);
        nc.send(n, 1'b0, 1'b0);
        tick(10);
    endtask
    task automatic t_reset;
        rd(OFS_SYNC_TYPE, 32'h0000_0000);
        rd(OFS_RATIO_NUM, 32'h0000_0001);
        rd(OFS_RATIO_DEN, 32'h0000_0001);
        rd(OFS_DIR_REL, 32'h0000_0003);
        rd(16'h0000, 32'h0000_0000);
        pos(0);
    endtask
    task automatic t_local;
        reference_input_format_select = 1'b1;
        enable_pin = 1'b1;
        act(1'b1);
        chk("power_stage_on", 32'h0000_0001, 32'(power_stage_on));
        nc.send(5, 1'b0, 1'b0);
        tick(20);
        pos(5);
        reference_input_format_select = 1'b0;
        tick(2);
        nc.send(4, 1'b1, 1'b1);
        tick(20);
        pos(1);
        nc.send(2, 1'b0, 1'b1);
        tick(20);
        pos(3);
        nc.send(2, 1'b1, 1'b1);
        tick(20);
        pos(1);
        reference_input_format_select = 1'b1;
        // motor still turning: the stop must wait for standstill
        motor_standstill = 1'b0;
        enable_pin = 1'b0;
        act(1'b0);
        tick(2);
        chk("power_stage_on", 32'h0000_0001, 32'(power_stage_on));
        motor_standstill = 1'b1;
        tick(2);
        chk("power_stage_on", 32'h0000_0000, 32'(power_stage_on));
        nc.send(4, 1'b0, 1'b0);
        enable_pin = 1'b1;
        act(1'b1);
        tick(20);
        pos(1);
        halt_req = 1'b1;
        tick(2);
        chk("gear_active", 32'h0000_0000, 32'(gear_active));
        halt_req = 1'b0;
        enable_pin = 1'b0;
    endtask
    task automatic t_bus;
        fieldbus_ctrl = 1'b1;
        pw(1'b1, OFS_SYNC_TYPE, 32'h0000_0003);
        rd(OFS_SYNC_TYPE, 32'h0000_0000);
        pw(1'b1, OFS_RATIO_DEN, 32'h0000_0001);
        pw(1'b1, OFS_RATIO_NUM, 32'hffff_fffe);
        pw(1'b1, OFS_SYNC_TYPE, 32'h0000_0002);
        act(1'b1);
        nc.send(3, 1'b0, 1'b0);
        tick(20);
        pos(-5);
        gap(4);
        pw(1'b1, OFS_SYNC_TYPE, 32'h0000_0002);
        tick(40);
        pos(-13);
        bop(4'h0);
        bop(OPMODE_GEAR);
        act(1'b1);
        gap(4);
        pw(1'b1, OFS_SYNC_TYPE, 32'h0000_0001);
        act(1'b1);
        tick(40);
        pos(-13);
        pw(1'b1, OFS_DIR_REL, 32'h0000_0001);
        nc.send(2, 1'b0, 1'b0);
        tick(20);
        pos(-13);
        pw(1'b1, OFS_DIR_REL, 32'h0000_0002);
        nc.send(1, 1'b0, 1'b0);
        tick(20);
        pos(-15);
        fault = 1'b1;
        tick(2);
        chk("power_stage_on", 32'h0000_0000, 32'(power_stage_on));
        fault = 1'b0;
    endtask
    // free-running clock, 8 ns period
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // watchdog, far beyond the few hundred cycles expected
    initial
    begin
        #200000;
        failures++;
        finish_test();
    end
    initial
    begin
        {reference_input_format_select, fieldbus_ctrl, enable_pin, bus_opmode_wr, halt_req, fault} = '0;
        local_default_operating_mode = OPMODE_GEAR;
        bus_operating_mode_select = 4'h0;
        motor_standstill = 1'b1;
        par_req = '0;
        failures = 0;
        tests_run = 0;
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        tick(1);
        t_reset();
        t_local();
        t_bus();
        finish_test();
    end
endmodule
bind electronic_gear_follower gear_properties chk_i (
    .mclk(mclk), .nrst(nrst), .fieldbus_ctrl(fieldbus_ctrl), .enable_pin(enable_pin),
    .local_default_operating_mode(local_default_operating_mode),
    .bus_opmode_wr(bus_opmode_wr), .bus_operating_mode_select(bus_operating_mode_select),
    .halt_req(halt_req), .fault(fault), .par_req(par_req), .power_stage_on(power_stage_on),
    .gear_active(gear_active), .set_position(set_position)
);

// [gear_follower_properties.sv]
// checker for the gear follower: mode start/stop and target stepping
// assumes it is bound onto the follower top and sees its ports only
`timescale 1ns/100ps
module gear_properties (
    input wire logic mclk, // control clock
    input wire logic nrst, // async reset, active low
    input wire logic fieldbus_ctrl, // control source
    input wire logic enable_pin, // local enable
    input wire logic [3:0] local_default_operating_mode, // local mode
    input wire logic bus_opmode_wr, // bus mode strobe
    input wire logic [3:0] bus_operating_mode_select, // bus mode value
    input wire logic halt_req, // halt level
    input wire logic fault, // error level
    input wire gear_pkg::par_req_t par_req, // parameter access
    input wire logic power_stage_on, // amplifier on
    input wire logic gear_active, // follower running
    input wire logic signed [31:0] set_position // motor target
);
    import gear_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // enable rise under local control with gear mode chosen
    sequence s_local_start;
        !fieldbus_ctrl && local_default_operating_mode == OPMODE_GEAR && !halt_req && !fault ##0 $rose(enable_pin);
    endsequence
    // amplifier off on two edges in a row
    sequence s_idle_two;
        !power_stage_on ##1 !power_stage_on;
    endsequence
    a_power_when_running: assert property (gear_active |-> power_stage_on) else $error("running without power");
    a_local_enable_start: assert property (s_local_start |-> ##[1:4] gear_active) else $error("no local start");
    a_bus_mode_start: assert property (fieldbus_ctrl && bus_opmode_wr && !halt_req && !fault
        && bus_operating_mode_select == OPMODE_GEAR |=> gear_active) else $error("no bus start");
    a_sync_write_start: assert property (fieldbus_ctrl && par_req.wr && par_req.addr == OFS_SYNC_TYPE && !halt_req
        && !fault && par_req.wdata inside {32'h0000_0001, 32'h0000_0002} |=> gear_active) else $error("no sync start");
    a_halt_stops: assert property (halt_req |=> !gear_active) else $error("halt ignored");
    a_fault_stops: assert property (fault |=> !power_stage_on) else $error("fault ignored");
    a_idle_holds: assert property (s_idle_two |-> $stable(set_position)) else $error("moved while idle");
    a_single_step: assert property ($changed(set_position)
        |-> (set_position - $past(set_position)) inside {32'h0000_0001, 32'hffff_ffff}) else $error("step size");
endmodule

// [gear_pkg.sv]
// constants, types and parameter offsets for the electronic gear follower
// assumes one 125 MHz clock and a simple parameter write/read port
// Behaviour
// R1 - reference is quadrature or pulse/direction, selectable
// R2 - local: enable starts default mode, powers stage
// R3 - bus mode write selects and starts gear
// R4 - sync type write sets type and starts
// R5 - reference changes scaled by gear, motor follows
// R6 - internal units, changes applied at once; code moves at most one increment per cycle, so large ratios lag
// R7 - ends on disable at standstill, halt, error
// R8 - 131072 motor increments per revolution
// R9 - ratio, direction same for every sync type
// R10 - local: changes during interruption are discarded
// R11 - bus: interruption changes counted, replayed or dropped
// R12 - sync type 16 bit: 0 off,1 realtime,2 compensate
// R13 - factor numerator over denominator, negative reverses
// R14 - ratio resets to one to one
// R15 - direction release 1 pos, 2 neg, 3 both
// R16 - signed remainder carried, no increments lost
package gear_pkg;
    // parameter offsets
    localparam logic [15:0] OFS_SYNC_TYPE = 16'h1b24;
    localparam logic [15:0] OFS_RATIO_DEN = 16'h2606;
    localparam logic [15:0] OFS_RATIO_NUM = 16'h2608;
    localparam logic [15:0] OFS_DIR_REL = 16'h260a;
    // sync type codes and reset
    localparam logic [15:0] SYNC_OFF = 16'h0000;
    localparam logic [15:0] SYNC_REALTIME = 16'h0001;
    localparam logic [15:0] SYNC_COMPENSATE = 16'h0002;
    localparam logic [15:0] SYNC_MAX = 16'h0002;
    localparam logic [15:0] SYNC_RESET = 16'h0000;
    // direction release codes
    localparam logic [15:0] DIR_POS = 16'h0001;
    localparam logic [15:0] DIR_NEG = 16'h0002;
    localparam logic [15:0] DIR_BOTH = 16'h0003;
    // ratio reset values, one to one
    localparam logic signed [31:0] NUM_RESET = 32'sh0000_0001;
    localparam logic [31:0] DEN_RESET = 32'h0000_0001;
    // operating mode code meaning electronic gear (arbitrary value)
    localparam logic [3:0] OPMODE_GEAR = 4'h3;
    // motor resolution
    localparam logic [16:0] INC_PER_REV_M1 = 17'h1_ffff;
    localparam int INC_PER_REV = 131072;

    // follower state, one-hot
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_STOP = 3'b100
    } gear_state_t;

    // parameter access request
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } par_req_t;

    // raw reference pins
    typedef struct packed
    {
        logic a_pulse;
        logic b_dir;
    } ref_pins_t;
endpackage

// [nc_ref_source.sv]
// upstream reference source: a/b quadrature or pulse/direction levels
// assumes send is called at a falling edge of mclk
`timescale 1ns/100ps
module nc_ref_source (
    input wire logic mclk, // pacing clock
    output gear_pkg::ref_pins_t pins // pins toward the drive
);
    logic [1:0] ph; // quadrature phase index
    initial
    begin
        pins = '0;
        ph = 2'h0;
    end
    // n steps; every level held 4 cycles, above the sync need
    task automatic send(input int n, input logic down, input logic quad);
        repeat (n)
        begin
            if (quad)
            begin
                ph = down ? ph - 2'h1 : ph + 2'h1;
                pins = '{ph[1] ^ ph[0], ph[1]};
                repeat (4) @(negedge mclk);
            end
            else
            begin
                pins.b_dir = down;
                repeat (4) @(negedge mclk);
                pins.a_pulse = 1'b1;
                repeat (4) @(negedge mclk);
                pins.a_pulse = 1'b0;
            end
        end
        repeat (4) @(negedge mclk);
    endtask
endmodule
